// [rtl/tsc_capture.sv]
// Purpose: Minutes and hours capture registers for recorded events
// Assumes: Clock core supplies BCD minutes/hours in the timekeeping domain
// Notes: Event detection and counter live elsewhere; they drive the strobe
//        Clear beats a same-cycle strobe, so a cleared pair never reads half-filled
`timescale 1ns/1ps
module tsc_capture (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire tsc_pkg::tsc_time_t clock_now,
    input wire logic hour_format_12,
    input wire logic capture_strobe,
    input wire logic capture_enable,
    input wire logic capture_overwrite_select,
    input wire logic capture_clear,
    input wire tsc_pkg::tsc_req_t req,
    output logic [7:0] rdata,
    output logic captured
);
    // ********************************
    // Capture decision
    // ********************************
    logic take;
    logic [6:0] min_held;
    logic [5:0] hour_held;
    logic [7:0] hour_src;

    // Clock core runs on sys_clk, so its values need no synchroniser
    // First-event mode keeps the earliest stamp until cleared
    assign take = capture_strobe && capture_enable
        && (capture_overwrite_select || !captured);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            captured <= 1'b0;
        end else if (capture_clear) begin
            captured <= 1'b0;
        end else if (take) begin
            captured <= 1'b1;
        end
    end

    // Meridian flag only survives in 12-hour mode; 24-hour keeps tens bit 5
    always_comb begin
        if (hour_format_12) begin
            hour_src = clock_now.hours & tsc_pkg::HOUR12_MASK;
        end else begin
            hour_src = clock_now.hours & tsc_pkg::HOUR24_MASK;
        end
    end

    // ********************************
    // Capture registers
    // ********************************
    // Same strobe feeds both, so the pair is never torn
    tsc_capture_reg #(
        .WIDTH(tsc_pkg::MIN_MSB + 1),
        .RESET_VALUE(tsc_pkg::MIN_CAP_RESET)
    ) u_min (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .capture(take),
        .clear(capture_clear),
        .value(clock_now.minutes[tsc_pkg::MIN_MSB:0]),
        .held(min_held)
    );

    tsc_capture_reg #(
        .WIDTH(tsc_pkg::HOUR24_MSB + 1),
        .RESET_VALUE(tsc_pkg::HOUR_CAP_RESET)
    ) u_hour (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .capture(take),
        .clear(capture_clear),
        .value(hour_src[tsc_pkg::HOUR24_MSB:0]),
        .held(hour_held)
    );

    // ********************************
    // Register read port
    // ********************************
    // Writes are not decoded at all, so they cannot disturb anything
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                tsc_pkg::MIN_CAP_OFFSET: rdata <= {1'b0, min_held};
                tsc_pkg::HOUR_CAP_OFFSET: rdata <= {2'b00, hour_held};
                default: rdata <= 8'h00;
            endcase
        end
    end

    // ********************************
    // Elaboration checks
    // ********************************
    // The read port pads each capture to a byte with zeros above the field
    if ($bits(min_held) != tsc_pkg::MIN_MSB + 1
        || $bits(hour_held) != tsc_pkg::HOUR24_MSB + 1
        || tsc_pkg::MERIDIAN_BIT != tsc_pkg::HOUR24_MSB) begin : g_bad_layout
        $error("tsc_capture: capture widths disagree with the register layout");
    end

    // ********************************
    // Assertions
    // ********************************
    // A gated strobe with no clear on the same edge
    sequence stamp_taken_s;
        take && !capture_clear;
    endsequence

    // A strobe offered while captures are allowed
    sequence strobe_taken_s;
        capture_strobe && capture_enable && !capture_clear;
    endsequence

    // First-event mode already holds a stamp, so this strobe must bounce off
    sequence first_locked_s;
        strobe_taken_s ##0 (captured && !capture_overwrite_select);
    endsequence

    // Host reads of the two capture offsets
    sequence read_min_s;
        req.rd && req.addr == tsc_pkg::MIN_CAP_OFFSET;
    endsequence

    sequence read_hour_s;
        req.rd && req.addr == tsc_pkg::HOUR_CAP_OFFSET;
    endsequence

    // ********************************
    // Capture checks
    // ********************************
    capture_min_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stamp_taken_s
        |=> min_held == $past(clock_now.minutes[6:0]))
        else $error("minutes capture did not follow clock");

    capture_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stamp_taken_s
        |=> min_held == $past(clock_now.minutes[6:0])
            && hour_held == $past(clock_now.hours[5:0]))
        else $error("hours capture not paired with minutes");

    hour24_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stamp_taken_s ##0 !hour_format_12
        |=> hour_held == $past(clock_now.hours[5:0]))
        else $error("24-hour capture wrong");

    meridian_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stamp_taken_s ##0 hour_format_12
        |=> hour_held[5] == $past(clock_now.hours[5])
            && hour_held[4:0] == $past(clock_now.hours[4:0]))
        else $error("12-hour capture or meridian wrong");

    // ********************************
    // Gate checks
    // ********************************
    enable_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !capture_enable && !capture_clear
        |=> $stable(min_held) && $stable(hour_held) && $stable(captured))
        else $error("capture while disabled");

    first_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        first_locked_s
        |=> $stable(min_held) && $stable(hour_held))
        else $error("first-event stamp overwritten");

    first_take_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strobe_taken_s ##0 !captured
        |=> captured && min_held == $past(clock_now.minutes[6:0]))
        else $error("first event not recorded");

    last_refresh_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strobe_taken_s ##0 capture_overwrite_select
        |=> captured && min_held == $past(clock_now.minutes[6:0])
            && hour_held == $past(clock_now.hours[5:0]))
        else $error("last-event mode did not refresh");

    clear_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        capture_clear
        |=> min_held == 7'h00 && hour_held == 6'h00
            && !captured)
        else $error("clear did not zero captures");

    captured_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !capture_strobe && !capture_clear
        |=> $stable(captured))
        else $error("capture flag moved without strobe or clear");

    // ********************************
    // Read port checks
    // ********************************
    write_ignored_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.wr && !take && !capture_clear
        |=> $stable(min_held) && $stable(hour_held) && $stable(captured))
        else $error("write changed capture registers");

    upper_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(req.rd)
        |-> rdata[7] == 1'b0
            && ($past(req.addr) != tsc_pkg::HOUR_CAP_OFFSET || rdata[6] == 1'b0))
        else $error("unused bits read nonzero");

    read_min_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        read_min_s
        |=> rdata == {1'b0, $past(min_held)})
        else $error("minutes capture read back wrong");

    read_hour_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        read_hour_s
        |=> rdata == {2'b00, $past(hour_held)})
        else $error("hours capture read back wrong");

    rdata_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !req.rd
        |=> $stable(rdata))
        else $error("read data moved without a read");
endmodule

// [rtl/tsc_capture_reg.sv]
// Purpose: One capture register with capture strobe and clear; enable and first/last select are decided by the caller
// Assumes: Strobe and clear are single-cycle pulses on sys_clk
// Notes: Clear wins over a same-cycle capture; both come from software/event logic
`timescale 1ns/1ps
module tsc_capture_reg #(
    parameter int WIDTH = 8,
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic capture,
    input wire logic clear,
    input wire logic [WIDTH-1:0] value,
    output logic [WIDTH-1:0] held
);
    // Held values are packed into a byte-wide read port, so wider fields cannot be served
    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
        $error("tsc_capture_reg: WIDTH must be 1 to 8");
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            held <= RESET_VALUE[WIDTH-1:0];
        end else if (clear) begin
            held <= '0;
        end else if (capture) begin
            held <= value;
        end
    end
endmodule

// [rtl/tsc_pkg.sv]
// Purpose: Shared constants and types for the minutes/hours capture block
// Assumes: One timekeeping clock; BCD clock values supplied by the clock core
// Notes: Register offsets are byte addresses on the documented register port
package tsc_pkg;
    localparam logic [7:0] MIN_CAP_OFFSET = 8'h16;
    localparam logic [7:0] HOUR_CAP_OFFSET = 8'h17;
    localparam logic [7:0] MIN_CAP_RESET = 8'h00;
    localparam logic [7:0] HOUR_CAP_RESET = 8'h00;
    localparam int MIN_MSB = 6;
    localparam int HOUR24_MSB = 5;
    localparam int HOUR12_MSB = 4;
    localparam int MERIDIAN_BIT = 5;
    localparam logic [7:0] MIN_MASK = 8'h7F;
    localparam logic [7:0] HOUR24_MASK = 8'h3F;
    localparam logic [7:0] HOUR12_MASK = 8'h3F;

    // Time pair carried from the clock core
    typedef struct packed {
        logic [7:0] minutes;
        logic [7:0] hours;
    } tsc_time_t;

    // Register port request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tsc_req_t;
endpackage

// [tb/testbench.sv]
// Purpose: Self-checking bench for the minutes/hours capture block
// Assumes: Inputs change on the falling edge; rdata is read a cycle after rd
// Notes: Event values carry stray upper bits to prove they never read back
`timescale 1ns/1ps
module testbench;
    logic sys_clk;
    logic rst_n;
    tsc_pkg::tsc_time_t clock_now;
    logic hour_format_12;
    logic capture_strobe;
    logic capture_enable;
    logic capture_overwrite_select;
    logic capture_clear;
    tsc_pkg::tsc_req_t req;
    logic [7:0] rdata;
    logic captured;
    int failures;
    int check_count;

    tsc_capture i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clock_now(clock_now),
        .hour_format_12(hour_format_12), .capture_strobe(capture_strobe),
        .capture_enable(capture_enable), .req(req), .rdata(rdata), .captured(captured),
        .capture_overwrite_select(capture_overwrite_select), .capture_clear(capture_clear));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic read_reg(input logic [7:0] addr, input logic [7:0] exp);
        req = '{1'b1, 1'b0, addr, 8'h00};
        @(negedge sys_clk);
        req.rd = 1'b0;
        @(negedge sys_clk);
        check8(rdata, exp);
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        req = '{1'b0, 1'b1, addr, data};
        @(negedge sys_clk);
        req.wr = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic stamp(input logic [7:0] mins, input logic [7:0] hrs, input logic clr);
        clock_now = '{mins, hrs};
        capture_strobe = 1'b1;
        capture_clear = clr;
        @(negedge sys_clk);
        capture_strobe = 1'b0;
        capture_clear = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        #200000;
        failures++;
        conclude();
    end

    initial begin
        failures = 0;
        check_count = 0;
        rst_n = 1'b0;
        clock_now = '{8'h00, 8'h00};
        {hour_format_12, capture_strobe, capture_enable} = 3'b000;
        {capture_overwrite_select, capture_clear} = 2'b00;
        req = '{1'b0, 1'b0, 8'h00, 8'h00};
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        read_reg(8'h16, 8'h00);
        read_reg(8'h17, 8'h00);
        stamp(8'h45, 8'h10, 1'b0);
        check_flag(captured, 1'b0);
        read_reg(8'h16, 8'h00);
        capture_enable = 1'b1;
        stamp(8'hD9, 8'hE3, 1'b0);
        stamp(8'h05, 8'h12, 1'b0);
        check_flag(captured, 1'b1);
        read_reg(8'h16, 8'h59);
        read_reg(8'h17, 8'h23);
        write_reg(8'h16, 8'hFF);
        write_reg(8'h17, 8'hFF);
        read_reg(8'h16, 8'h59);
        read_reg(8'h17, 8'h23);
        capture_overwrite_select = 1'b1;
        hour_format_12 = 1'b1;
        stamp(8'h30, 8'h32, 1'b0);
        read_reg(8'h17, 8'h32);
        stamp(8'h00, 8'hD1, 1'b0);
        read_reg(8'h17, 8'h11);
        read_reg(8'h16, 8'h00);
        stamp(8'h47, 8'h05, 1'b1);
        read_reg(8'h16, 8'h00);
        read_reg(8'h17, 8'h00);
        check_flag(captured, 1'b0);
        // Mid-run reset must drop held stamps and re-arm first-event mode
        stamp(8'h21, 8'h08, 1'b0);
        read_reg(8'h16, 8'h21);
        read_reg(8'h17, 8'h08);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        read_reg(8'h16, 8'h00);
        read_reg(8'h17, 8'h00);
        check_flag(captured, 1'b0);
        capture_overwrite_select = 1'b0;
        stamp(8'h33, 8'h07, 1'b0);
        stamp(8'h44, 8'h09, 1'b0);
        read_reg(8'h16, 8'h33);
        read_reg(8'h17, 8'h07);
        conclude();
    end
endmodule
